// ===== pbm_ctrl.v
/*
  Basic mode control register bank of a 10/100 PHY, reached over APB, with
  power-down, isolate, auto-negotiation restart, forced duplex and speed,
  and the collision test path from TX_EN to COL.
  Assumes an auto-negotiation engine on pclk that pulses an_started when a
  restart has begun and supplies the negotiated speed and duplex; pins and
  straps are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
`include "pbm_map.vh"
module pbm_ctrl #(
  parameter AW = 8,
  parameter COL_DLY = `PBM_COL_DLY_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire power_down_interrupt_pin_n,
  input wire strap_duplex,
  input wire strap_speed,
  input wire strap_an_enable,
  input wire tx_en,
  output wire col,
  output wire col_oe,
  output wire mii_isolate,
  output wire xcvr_power_down,
  output wire loopback,
  output wire an_enable,
  output wire an_restart,
  input wire an_started,
  input wire an_full_duplex,
  input wire an_speed_100,
  output wire full_duplex,
  output wire speed_100
);

  // ============================================================
  // Pin synchronisation
  wire pin_n_s;
  wire [2:0] strap_s;
  wire tx_en_s;

  pbm_sync #(.W(1), .RST(`PBM_RST_PIN_IDLE)) u_sync_pin (
    .pclk(pclk),
    .presetn(presetn),
    .d(power_down_interrupt_pin_n),
    .q(pin_n_s)
  );

  pbm_sync #(.W(3), .RST(3'h0)) u_sync_strap (
    .pclk(pclk),
    .presetn(presetn),
    .d({strap_an_enable, strap_speed, strap_duplex}),
    .q(strap_s)
  );

  pbm_sync #(.W(1), .RST(`PBM_RST_ZERO)) u_sync_txen (
    .pclk(pclk),
    .presetn(presetn),
    .d(tx_en),
    .q(tx_en_s)
  );

  wire pin_low = ~pin_n_s;

  // ============================================================
  // Strap capture after reset release
  // Straps are read only once they have crossed the synchroniser, so the
  // control fields hold zero for the first few cycles after release.
  reg [1:0] strap_cnt_q;
  wire strap_load = (strap_cnt_q == `PBM_STRAP_WAIT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // ============================================================
  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctl = (paddr == `PBM_OFF_CONTROL);
  wire hit_st = (paddr == `PBM_OFF_STATUS);
  wire wr_ctl = access & pwrite & hit_ctl;
  wire [15:0] wd = pwdata[15:0];

  // ============================================================
  // Control fields
  reg swrst_q;
  reg loop_q;
  reg speed_q;
  reg an_en_q;
  reg pd_q;
  reg iso_q;
  reg restart_q;
  reg duplex_q;
  reg coltest_q;
  reg an_restart_q;

  // A restart request counts only if negotiation is enabled by the same write.
  wire restart_ok = wr_ctl & wd[`PBM_BIT_AN_RESTART] & wd[`PBM_BIT_AN_ENABLE]; // [R6] [R7]
  wire reload = swrst_q | strap_load;

  reg restart_d;
  reg pd_d;

  always @* begin
    restart_d = restart_q;
    if (wr_ctl && !wd[`PBM_BIT_AN_RESTART]) begin
      restart_d = 1'b0; // [R9]
    end
    if (an_started) begin
      restart_d = 1'b0; // [R8]
    end
    if (restart_ok) begin
      restart_d = 1'b1; // [R8]
    end
    pd_d = pd_q;
    if (wr_ctl) begin
      pd_d = wd[`PBM_BIT_POWER_DOWN]; // [R1]
    end
    if (pin_low) begin
      pd_d = 1'b1; // [R4]
    end
  end

  // Register writes run regardless of power-down so software can wake the port.
  always @(posedge pclk or negedge presetn) begin // [R2]
    if (!presetn) begin
      swrst_q <= 1'b0;
      loop_q <= 1'b0;
      speed_q <= 1'b0;
      an_en_q <= 1'b0;
      pd_q <= 1'b0;
      iso_q <= 1'b0;
      restart_q <= 1'b0;
      duplex_q <= 1'b0;
      coltest_q <= 1'b0;
      an_restart_q <= 1'b0;
    end else if (reload) begin
      swrst_q <= 1'b0;
      loop_q <= 1'b0;
      speed_q <= strap_s[1];
      an_en_q <= strap_s[2];
      pd_q <= pin_low;
      iso_q <= 1'b0;
      restart_q <= 1'b0;
      duplex_q <= strap_s[0]; // [R15]
      coltest_q <= 1'b0;
      an_restart_q <= 1'b0;
    end else begin
      pd_q <= pd_d;
      restart_q <= restart_d;
      an_restart_q <= restart_ok; // [R6]
      if (wr_ctl) begin
        swrst_q <= wd[`PBM_BIT_SWRESET];
        loop_q <= wd[`PBM_BIT_LOOPBACK];
        speed_q <= wd[`PBM_BIT_SPEED];
        an_en_q <= wd[`PBM_BIT_AN_ENABLE];
        iso_q <= wd[`PBM_BIT_ISOLATE]; // [R5]
        duplex_q <= wd[`PBM_BIT_DUPLEX]; // [R10]
        coltest_q <= wd[`PBM_BIT_COL_TEST];
      end
    end
  end

  // ============================================================
  // Collision test
  wire col_raw;

  pbm_coltest #(.DLY(COL_DLY)) u_coltest (
    .pclk(pclk),
    .presetn(presetn),
    .enable(coltest_q),
    .tx_en(tx_en_s),
    .col(col_raw)
  );

  // ============================================================
  // Mode outputs
  wire pd_eff = pd_q | pin_low; // [R3]

  assign xcvr_power_down = pd_eff; // [R1]
  assign mii_isolate = iso_q;
  assign col = col_raw & ~iso_q;
  assign col_oe = ~iso_q; // [R5]
  assign loopback = loop_q;
  assign an_enable = an_en_q;
  assign an_restart = an_restart_q;
  assign full_duplex = an_en_q ? an_full_duplex : duplex_q; // [R14] [R10]
  assign speed_100 = an_en_q ? an_speed_100 : speed_q; // [R14]

  // ============================================================
  // Read data
  // Read data is sampled in the setup cycle, so the access cycle needs no wait.
  wire [15:0] ctl_rd = {swrst_q, loop_q, speed_q, an_en_q, pd_q, iso_q, restart_q,
                        duplex_q, coltest_q, 7'h00}; // [R13]
  wire [15:0] st_rd = {9'h000, pin_low, col, restart_q, speed_100, full_duplex,
                       iso_q, pd_eff};

  reg [31:0] prdata_q;
  reg pslverr_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~(hit_ctl | hit_st);
      if (hit_ctl) begin
        prdata_q <= {16'h0000, ctl_rd};
      end else if (hit_st) begin
        prdata_q <= {16'h0000, st_rd};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & access;
endmodule // pbm_ctrl

// ===== pbm_map.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  lower half of the PHY basic mode control block.
  Assumes it is included by its bare name from the block's design files.
*/
// How it works
// R1 - Power-down bit set to one powers the transceiver down; zero is normal.
// R2 - While powered down the register block keeps working, readable and writable.
// R3 - Effective power-down is the register bit ORed with the external pin.
// R4 - The active-low power-down pin held low sets the register power-down bit.
// R5 - Isolate bit ten cuts the port off the MII; management still works.
// R6 - Writing one to restart bit nine restarts auto-negotiation from the start.
// R7 - Restart writes are ignored while auto-negotiation enable bit twelve is zero.
// R8 - Restart bit reads one until negotiation has begun, then clears itself.
// R9 - Writing zero to the restart bit leaves running negotiation untouched.
// R10 - With negotiation off, duplex bit eight picks full (1) or half (0).
// R11 - With collision test set, COL rises within 512 bit times of TX_EN.
// R12 - With collision test set, COL falls within 4 bit times of TX_EN falling; the code takes three pclk cycles (150 ns) instead.
// R13 - Bits six to zero ignore writes and always read zero.
// R14 - Negotiation enabled ignores duplex and speed bits; disabled, they decide.
// R15 - The duplex bit's reset value comes from its strap input.
`ifndef PBM_MAP_VH
`define PBM_MAP_VH

// ============================================================
// Register offsets
`define PBM_OFF_CONTROL 8'h00
`define PBM_OFF_STATUS 8'h04

// ============================================================
// Control register field positions
`define PBM_BIT_SWRESET 15
`define PBM_BIT_LOOPBACK 14
`define PBM_BIT_SPEED 13
`define PBM_BIT_AN_ENABLE 12
`define PBM_BIT_POWER_DOWN 11
`define PBM_BIT_ISOLATE 10
`define PBM_BIT_AN_RESTART 9
`define PBM_BIT_DUPLEX 8
`define PBM_BIT_COL_TEST 7

// ============================================================
// Status register field positions
`define PBM_ST_POWER_DOWN 0
`define PBM_ST_ISOLATE 1
`define PBM_ST_FULL_DUPLEX 2
`define PBM_ST_SPEED_100 3
`define PBM_ST_RESTART_PEND 4
`define PBM_ST_COL 5
`define PBM_ST_PIN_LOW 6

// ============================================================
// Reset values
`define PBM_RST_ZERO 1'b0
`define PBM_RST_PIN_IDLE 1'b1

// ============================================================
// Timing
`define PBM_CLK_NS 50
`define PBM_BIT_NS 10
`define PBM_COL_ON_BITS 512
`define PBM_COL_OFF_BITS 4
`define PBM_COL_ON_CYC ((`PBM_COL_ON_BITS * `PBM_BIT_NS) / `PBM_CLK_NS)
`define PBM_COL_OFF_RAW ((`PBM_COL_OFF_BITS * `PBM_BIT_NS) / `PBM_CLK_NS)
`define PBM_COL_OFF_CYC ((`PBM_COL_OFF_RAW < 1) ? 1 : `PBM_COL_OFF_RAW)
`define PBM_COL_DLY_CYC 2
`define PBM_STRAP_WAIT 2'h2

`endif

// ===== pbm_sync.v
/*
  Two-flip-flop synchroniser for pins entering the pclk domain.
  Assumes each bit is an independent level.
*/
`timescale 1ns/1ns
module pbm_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // pbm_sync

// ===== pbm_coltest.v
/*
  Collision test generator: COL follows TX_EN while the test is enabled.
  Assumes tx_en is already synchronised to pclk.
*/
`timescale 1ns/1ns
module pbm_coltest #(
  parameter DLY = 2
) (
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire tx_en,
  output wire col
);
  reg [7:0] cnt_q;
  reg col_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      col_q <= 1'b0;
    end else if (!enable || !tx_en) begin
      cnt_q <= 8'h00;
      col_q <= 1'b0; // [R12]
    end else if (cnt_q >= DLY[7:0]) begin
      col_q <= 1'b1; // [R11]
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign col = col_q;
endmodule // pbm_coltest

// ===== pbm_an_model.sv
/*
  Behavioural auto-negotiation engine facing the control bank.
  Assumes the same pclk and presetn as the bank; the bench sets the latency.
*/
`timescale 1ns/1ns
// ============================================================
// Negotiation engine model
module pbm_an_model (
  input wire pclk,
  input wire presetn,
  input wire an_restart,
  input wire [15:0] lat,
  input wire res_fd,
  input wire res_sp,
  output wire an_started,
  output wire an_full_duplex,
  output wire an_speed_100
);
  logic [15:0] cnt_q;
  logic started_q;
  // A new restart reloads the count; register writes never reach here.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      started_q <= 1'b0;
    end else begin
      started_q <= (cnt_q == 16'h0001);
      if (an_restart) cnt_q <= lat;
      else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign an_started = started_q;
  assign an_full_duplex = res_fd;
  assign an_speed_100 = res_sp;
endmodule // pbm_an_model

// ===== pbm_ctrl_checker.sv
/*
  Port assertions for the basic mode control bank.
  Assumes it is bound onto pbm_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
// ============================================================
// Checker
module pbm_ctrl_checker #(parameter AW = 8) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire power_down_interrupt_pin_n,
  input wire tx_en,
  input wire col,
  input wire col_oe,
  input wire mii_isolate,
  input wire xcvr_power_down,
  input wire an_enable,
  input wire an_restart,
  input wire an_full_duplex,
  input wire full_duplex
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Software reset writes reload from straps, so they are left out here.
  wire wr = psel && penable && pwrite && paddr == 0 && !pwdata[15];
  property p_pd_write; wr && pwdata[11] |=> xcvr_power_down; endproperty
  a_pd_write: assert property (p_pd_write)
    else $error("power-down write not applied");
  property p_pd_pin; !power_down_interrupt_pin_n [*4] |-> xcvr_power_down; endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("pin low without power-down");
  property p_iso_write; wr && pwdata[10] |=> mii_isolate && !col_oe; endproperty
  a_iso_write: assert property (p_iso_write)
    else $error("isolate write not applied");
  property p_iso_col; mii_isolate && $past(mii_isolate) |-> !col; endproperty
  a_iso_col: assert property (p_iso_col)
    else $error("collision driven while isolated");
  property p_restart; wr && pwdata[9] && pwdata[12] |=> an_restart; endproperty
  a_restart: assert property (p_restart)
    else $error("restart not issued");
  property p_restart_off; wr && pwdata[9] && !pwdata[12] |=> !an_restart; endproperty
  a_restart_off: assert property (p_restart_off)
    else $error("restart issued while negotiation off");
  property p_an_mux;
    an_enable && $stable(an_enable) && $stable(an_full_duplex) |-> full_duplex == an_full_duplex;
  endproperty
  a_an_mux: assert property (p_an_mux)
    else $error("duplex not taken from negotiation");
  property p_col_off; !tx_en [*5] |-> !col; endproperty
  a_col_off: assert property (p_col_off)
    else $error("collision held after transmit end");
  c_restart: cover property (an_restart);
  c_col: cover property (col);
  c_pin: cover property (!power_down_interrupt_pin_n && xcvr_power_down);
endmodule // pbm_ctrl_checker
bind pbm_ctrl pbm_ctrl_checker #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .power_down_interrupt_pin_n(power_down_interrupt_pin_n), .tx_en(tx_en), .col(col),
  .col_oe(col_oe), .mii_isolate(mii_isolate), .xcvr_power_down(xcvr_power_down),
  .an_enable(an_enable), .an_restart(an_restart), .an_full_duplex(an_full_duplex),
  .full_duplex(full_duplex));

// ===== test_phy_basic_mode_control_low.sv
/*
  Self-checking bench for the basic mode control bank with a bench model.
  Assumes zero-wait APB and the negotiation engine model beside the bank.
*/
`timescale 1ns/1ns
module test_phy_basic_mode_control_low;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_en = 0;
  logic power_down_interrupt_pin_n = 1, strap_duplex = 1, strap_speed = 0;
  logic strap_an_enable = 1, res_fd = 0, res_sp = 0, pend = 0, e;
  logic [7:0] paddr = 0;
  logic [15:0] lat = 16'h03e8, m;
  logic [31:0] pwdata = 0, rd, lf = 32'h60dd06e5;
  wire [31:0] prdata;
  wire pready, pslverr, col, col_oe, mii_isolate, xcvr_power_down, loopback;
  wire an_enable, an_restart, an_started, an_full_duplex, an_speed_100;
  wire full_duplex, speed_100;
  int error_cnt = 0, samples_checked = 0, starts = 0, n;
  pbm_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .power_down_interrupt_pin_n(power_down_interrupt_pin_n),
    .strap_duplex(strap_duplex), .strap_speed(strap_speed),
    .strap_an_enable(strap_an_enable), .tx_en(tx_en), .col(col), .col_oe(col_oe),
    .mii_isolate(mii_isolate), .xcvr_power_down(xcvr_power_down), .loopback(loopback),
    .an_enable(an_enable), .an_restart(an_restart), .an_started(an_started),
    .an_full_duplex(an_full_duplex), .an_speed_100(an_speed_100),
    .full_duplex(full_duplex), .speed_100(speed_100));
  pbm_an_model u_an (.pclk(pclk), .presetn(presetn), .an_restart(an_restart), .lat(lat),
    .res_fd(res_fd), .res_sp(res_sp), .an_started(an_started),
    .an_full_duplex(an_full_duplex), .an_speed_100(an_speed_100));
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) if (an_started === 1'b1) starts++;
  // ============================================================
  // Helpers
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // The model keeps only writable bits; a low pin forces power-down on.
  task wrm(input logic [15:0] d);
    apb(1, 8'h00, {16'h0000, d});
    m = (d & 16'h7d80) | (power_down_interrupt_pin_n ? 16'h0000 : 16'h0800);
    if (d[9] && d[12]) pend = 1;
    else if (!d[9]) pend = 0;
  endtask
  task rdc;
    apb(0, 8'h00, 0);
    chk(rd, {16'h0000, m | (pend ? 16'h0200 : 16'h0000)});
  endtask
  task tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish;
  end
  // ============================================================
  // Tests
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    m = 16'h1100;
    rdc();
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      res_fd <= lf[16]; res_sp <= lf[17];
      wrm(lf[15:0] & 16'h7fff);
      rdc();
      chk(xcvr_power_down, m[11]);
      chk(mii_isolate, m[10]);
      chk(full_duplex, m[12] ? res_fd : m[8]);
      chk(speed_100, m[12] ? res_sp : m[13]);
      chk(an_enable, m[12]);
      chk(loopback, m[14]);
      chk(col_oe, !m[10]);
      chk(pready, 1);
    end
    $display("test random done");
    lat <= 16'h0028;
    starts = 0;
    wrm(16'h1200);
    rdc();
    repeat (50) @(posedge pclk);
    pend = 0;
    rdc();
    chk(starts, 1);
    wrm(16'h1200);
    wrm(16'h1000);
    rdc();
    repeat (50) @(posedge pclk);
    chk(starts, 2);
    wrm(16'h0200);
    rdc();
    $display("test restart done");
    @(posedge pclk) power_down_interrupt_pin_n <= 0;
    repeat (5) @(posedge pclk);
    chk(xcvr_power_down, 1);
    wrm(16'h0000);
    rdc();
    @(posedge pclk) power_down_interrupt_pin_n <= 1;
    repeat (3) @(posedge pclk);
    wrm(16'h0000);
    rdc();
    chk(xcvr_power_down, 0);
    $display("test power-down done");
    // Software reset reloads speed, enable and duplex from the straps one cycle later; power-down follows the pin, the rest clear.
    wrm(16'h8000);
    m = 16'h1100;
    rdc();
    apb(0, 8'h04, 0);
    chk(rd, {28'h0000000, res_sp, res_fd, 2'b00});
    chk(e, 0);
    $display("test soft reset done");
    // Four bit times is under one clock, so fall uses the three-cycle figure.
    wrm(16'h0080);
    @(posedge pclk) tx_en <= 1;
    // Sample one step after each edge, where the registered COL has settled.
    for (n = 0; col !== 1'b1 && n < 200; n++) @(posedge pclk) #1;
    chk(n <= 102, 1);
    @(posedge pclk) tx_en <= 0;
    for (n = 0; col !== 1'b0 && n < 200; n++) @(posedge pclk) #1;
    chk(n <= 3, 1);
    wrm(16'h0480);
    @(posedge pclk) tx_en <= 1;
    repeat (10) @(posedge pclk);
    chk(col, 0);
    chk(col_oe, 0);
    tx_en <= 0;
    apb(0, 8'h08, 0);
    chk(e, 1);
    chk(rd, 0);
    $display("test collision done");
    tally_and_finish;
  end
endmodule // test_phy_basic_mode_control_low
